// >>> core/sdram_cmd_cfg.svh
// Constants for the synchronous DRAM command and address decoder.
// Assumes inclusion by bare name from the package and the decoder.
`ifndef SDRAM_CMD_CFG_SVH
`define SDRAM_CMD_CFG_SVH
`define ADDR_W 12
`define BANKS 4
`define AP_BIT 10
`define ORG_X4 2'h0
`define ORG_X8 2'h1
`define ORG_X16 2'h2
`define COL_W 12
`define BURST_LEN_DEF 4'h4
`define MASK_RD_LAT 2
`endif

// >>> core/sdram_cmd_pkg.sv
// Types for the synchronous DRAM command and address decoder.
// Assumes the constants header sits beside it.
`include "sdram_cmd_cfg.svh"
package sdram_cmd_pkg;
  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_MRS, CMD_BST
  } cmd_t;
  typedef enum logic [1:0] {CLK_RUN, CLK_SUSPEND, CLK_POWERDOWN, CLK_SELFREF} clk_mode_t;
endpackage

// >>> core/sdram_cmd_decode.sv
// Command and address decoder of a four-bank synchronous DRAM.
// Assumes pins arrive asynchronously and pass two flip-flops first.
`timescale 1ns/100ps
`include "sdram_cmd_cfg.svh"
module sdram_cmd_decode (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [1:0] orgSelect,
  input wire logic clockEnable,
  input wire logic chipSelect_n,
  input wire logic rowStrobe_n,
  input wire logic columnStrobe_n,
  input wire logic writeStrobe_n,
  input wire logic [`ADDR_W-1:0] addressPins,
  input wire logic array_select_bit0,
  input wire logic array_select_bit1,
  input wire logic dataMask,
  output sdram_cmd_pkg::cmd_t command,
  output logic commandValid,
  output logic [`ADDR_W-1:0] row_address,
  output logic [`COL_W-1:0] column_address,
  output logic [1:0] bankSelect,
  output logic auto_precharge_flag,
  output logic [`BANKS-1:0] bankOpen,
  output logic burstActive,
  output sdram_cmd_pkg::clk_mode_t clockMode,
  output logic writeBlocked,
  output logic readOutputEnable
);
  import sdram_cmd_pkg::*;

  // Two-stage input synchronisers
  localparam int PW = 1 + 1 + 3 + `ADDR_W + 2 + 1 + 2;
  logic [PW-1:0] pinMeta, pinSync;
  always_ff @(posedge mclk) begin
    pinMeta <= {clockEnable, chipSelect_n, rowStrobe_n, columnStrobe_n, writeStrobe_n,
      addressPins, array_select_bit1, array_select_bit0, dataMask, orgSelect};
    pinSync <= pinMeta;
  end

  logic cke, csN, mask;
  logic [2:0] strobes;
  logic [`ADDR_W-1:0] addr;
  logic [1:0] bank;
  logic [1:0] org;
  assign {cke, csN, strobes, addr, bank, mask, org} = pinSync;

  // Decode of the strobe levels
  cmd_t decoded;
  always_comb begin
    case (strobes)
      3'h3: decoded = CMD_ACT;
      3'h5: decoded = CMD_RD;
      3'h4: decoded = CMD_WR;
      3'h2: decoded = CMD_PRE;
      3'h1: decoded = CMD_REF;
      3'h0: decoded = CMD_MRS;
      3'h6: decoded = CMD_BST;
      default: decoded = CMD_NOP;
    endcase
  end

  // Registered state and next values
  logic ckePrev;
  logic [3:0] burstCount;
  logic apPending;
  logic [1:0] apBank;
  logic [`MASK_RD_LAT-1:0] maskPipe;
  logic next_ckePrev;
  clk_mode_t next_clockMode;
  cmd_t next_command;
  logic next_commandValid;
  logic [`ADDR_W-1:0] next_row_address;
  logic [`COL_W-1:0] next_column_address;
  logic [1:0] next_bankSelect;
  logic next_auto_precharge_flag;
  logic [3:0] next_burstCount;
  logic next_burstActive;
  logic next_apPending;
  logic [1:0] next_apBank;
  wire logic [`BANKS-1:0] next_bankOpen;
  logic [`MASK_RD_LAT-1:0] next_maskPipe;
  logic next_writeBlocked;
  logic next_readOutputEnable;

  // Internal clock runs while clock enable was seen high
  logic clkOn;
  logic accept;
  logic burstEnd;
  logic apClose;
  assign clkOn = ckePrev;
  assign accept = clkOn && !csN && (clockMode == CLK_RUN);
  assign burstEnd = clkOn && (burstCount == 4'h1);
  assign apClose = burstEnd && apPending;

  // Clock enable tracking and low-power mode
  always_comb begin
    next_ckePrev = cke;
    next_clockMode = clockMode;
    if (ckePrev && !cke) begin
      if (burstActive || burstCount > 4'h1) begin
        next_clockMode = CLK_SUSPEND;
      end else if (!csN && decoded == CMD_REF) begin
        next_clockMode = CLK_SELFREF;
      end else begin
        next_clockMode = CLK_POWERDOWN;
      end
    end else if (!ckePrev && cke) begin
      next_clockMode = CLK_RUN;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ckePrev <= 1'b0;
      clockMode <= CLK_RUN;
    end else begin
      ckePrev <= next_ckePrev;
      clockMode <= next_clockMode;
    end
  end

  // Accepted command and its one-cycle strobe
  always_comb begin
    next_command = command;
    next_commandValid = 1'b0;
    if (accept) begin
      next_command = decoded;
      next_commandValid = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      command <= CMD_NOP;
      commandValid <= 1'b0;
    end else begin
      command <= next_command;
      commandValid <= next_commandValid;
    end
  end

  // Row, column, bank and auto-precharge capture
  always_comb begin
    next_row_address = row_address;
    next_column_address = column_address;
    next_bankSelect = bankSelect;
    next_auto_precharge_flag = auto_precharge_flag;
    if (accept) begin
      case (decoded)
        CMD_ACT: begin
          next_row_address = addr;
          next_bankSelect = bank;
        end
        CMD_RD, CMD_WR: begin
          next_bankSelect = bank;
          next_auto_precharge_flag = addr[`AP_BIT];
          case (org)
            `ORG_X4: next_column_address = {addr[11], 1'b0, addr[9:0]};
            `ORG_X8: next_column_address = {2'h0, addr[9:0]};
            default: next_column_address = {3'h0, addr[8:0]};
          endcase
        end
        CMD_PRE: begin
          next_bankSelect = bank;
          next_auto_precharge_flag = addr[`AP_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      row_address <= '0;
      column_address <= '0;
      bankSelect <= 2'h0;
      auto_precharge_flag <= 1'b0;
    end else begin
      row_address <= next_row_address;
      column_address <= next_column_address;
      bankSelect <= next_bankSelect;
      auto_precharge_flag <= next_auto_precharge_flag;
    end
  end

  // Burst countdown, kept running while deselected
  always_comb begin
    next_burstCount = burstCount;
    next_burstActive = burstActive;
    next_apPending = apPending;
    next_apBank = apBank;
    if (clkOn && burstCount != 4'h0) begin
      next_burstCount = burstCount - 4'h1;
    end
    if (burstEnd) begin
      next_burstActive = 1'b0;
      next_apPending = 1'b0;
    end
    if (accept) begin
      case (decoded)
        CMD_RD, CMD_WR: begin
          next_apPending = addr[`AP_BIT];
          next_apBank = bank;
          next_burstCount = `BURST_LEN_DEF;
          next_burstActive = 1'b1;
        end
        CMD_BST: begin
          next_burstCount = 4'h0;
          next_burstActive = 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      burstCount <= 4'h0;
      burstActive <= 1'b0;
      apPending <= 1'b0;
      apBank <= 2'h0;
    end else begin
      burstCount <= next_burstCount;
      burstActive <= next_burstActive;
      apPending <= next_apPending;
      apBank <= next_apBank;
    end
  end

  // Per-bank open flags; an activate in the same cycle wins over a close
  genvar gb;
  generate
    for (gb = 0; gb < `BANKS; gb++) begin : g_bank
      localparam logic [1:0] IDX = 2'(gb);
      logic nextOpen;
      always_comb begin
        nextOpen = bankOpen[gb];
        if (apClose && apBank == IDX) begin
          nextOpen = 1'b0;
        end
        if (accept && decoded == CMD_PRE) begin
          if (addr[`AP_BIT]) begin
            nextOpen = 1'b0;
          end else if (bank == IDX) begin
            nextOpen = 1'b0;
          end
        end
        if (accept && decoded == CMD_ACT && bank == IDX) begin
          nextOpen = 1'b1;
        end
      end
      assign next_bankOpen[gb] = nextOpen;
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bankOpen <= '0;
    end else begin
      bankOpen <= next_bankOpen;
    end
  end

  // Mask pipeline: write side immediate, read side two cycles later
  always_comb begin
    next_maskPipe = maskPipe;
    next_writeBlocked = writeBlocked;
    next_readOutputEnable = readOutputEnable;
    if (clkOn) begin
      next_maskPipe = {maskPipe[`MASK_RD_LAT-2:0], mask};
      next_readOutputEnable = !maskPipe[`MASK_RD_LAT-1];
      next_writeBlocked = mask;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      maskPipe <= '0;
      writeBlocked <= 1'b0;
      readOutputEnable <= 1'b1;
    end else begin
      maskPipe <= next_maskPipe;
      writeBlocked <= next_writeBlocked;
      readOutputEnable <= next_readOutputEnable;
    end
  end
endmodule // sdram_cmd_decode

// >>> verification/sdram_ctrl_model.sv
// Controller model that drives the command, address and bank pins.
// Assumes calls begin just after a rising edge of mclk.
`timescale 1ns/100ps
module sdram_ctrl_model (
  input wire logic mclk,
  output logic chipSelect_n,
  output logic rowStrobe_n,
  output logic columnStrobe_n,
  output logic writeStrobe_n,
  output logic [11:0] addressPins,
  output logic array_select_bit0,
  output logic array_select_bit1
);
  initial begin
    {chipSelect_n, rowStrobe_n, columnStrobe_n, writeStrobe_n} = 4'hF;
    {array_select_bit1, array_select_bit0, addressPins} = 14'h0000;
  end
  task automatic issue(input logic [2:0] c, input logic [11:0] a, input logic [1:0] b,
      input logic s);
    @(negedge mclk);
    chipSelect_n = s;
    {rowStrobe_n, columnStrobe_n, writeStrobe_n} = c;
    {array_select_bit1, array_select_bit0, addressPins} = {b, a};
    @(negedge mclk);
    {chipSelect_n, rowStrobe_n, columnStrobe_n, writeStrobe_n} = 4'hF;
    {array_select_bit1, array_select_bit0, addressPins} = ~{b, a};
  endtask
endmodule // sdram_ctrl_model

// >>> verification/sdram_cmd_decode_assertions.sv
// Checker on the decoder ports, bound below.
// Assumes one clock and a synchronous high reset.
`timescale 1ns/100ps
module sdram_cmd_decode_assertions
  import sdram_cmd_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [1:0] orgSelect,
  input wire logic chipSelect_n,
  input wire logic rowStrobe_n,
  input wire logic columnStrobe_n,
  input wire logic writeStrobe_n,
  input wire logic [11:0] addressPins,
  input wire sdram_cmd_pkg::cmd_t command,
  input wire logic commandValid,
  input wire logic [11:0] row_address,
  input wire logic [11:0] column_address,
  input wire logic [1:0] bankSelect,
  input wire logic auto_precharge_flag,
  input wire logic [3:0] bankOpen,
  input wire logic burstActive
);
  localparam logic [23:0] ENC = 24'hC0A95F;
  wire logic [11:0] colMask = orgSelect == 2'h0 ? 12'hBFF : orgSelect == 2'h1 ? 12'h3FF : 12'h1FF;
  wire logic rw = commandValid && (command == CMD_RD || command == CMD_WR);
  wire logic pre = commandValid && command == CMD_PRE;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  desel_ignored_a: assert property (
    commandValid |-> !$past(chipSelect_n, 3)) else $error("command while deselected");
  cmd_enc_a: assert property (
    commandValid |-> ENC[3*command +: 3] == $past({rowStrobe_n, columnStrobe_n, writeStrobe_n}, 3))
    else $error("command not from strobes");
  act_row_a: assert property (commandValid && command == CMD_ACT |->
    row_address == $past(addressPins, 3) && bankOpen[bankSelect]) else $error("row not taken");
  col_addr_a: assert property (
    rw |-> (column_address & colMask) == ($past(addressPins, 3) & colMask)) else $error("bad column");
  pre_all_a: assert property (
    pre && auto_precharge_flag |-> bankOpen == 4'h0) else $error("banks left open");
  pre_one_a: assert property (pre && !auto_precharge_flag |->
    bankOpen == ($past(bankOpen) & ~(4'h1 << bankSelect))) else $error("wrong bank closed");
  ap_close_a: assert property (
    $fell(burstActive) && auto_precharge_flag |-> !bankOpen[bankSelect]) else $error("no autoclose");
  keep_open_a: assert property (
    $fell(burstActive) && !auto_precharge_flag |-> bankOpen[bankSelect]) else $error("bank closed");
  burst_run_a: assert property ($rose(burstActive) ##0 $past(chipSelect_n, 2) &&
    $past(chipSelect_n) && chipSelect_n |-> burstActive[*4]) else $error("burst cut short");
  cover property (rw && auto_precharge_flag);
  cover property (pre && auto_precharge_flag);
  cover property (commandValid && command == CMD_ACT);
endmodule // sdram_cmd_decode_assertions
bind sdram_cmd_decode sdram_cmd_decode_assertions sdram_cmd_decode_assertions_i (.*);

// >>> verification/test_sdram_command_address_decode.sv
// Self-checking bench for the decoder, command, address and bank pins from the controller model.
// Assumes the model and checker files compile first.
`timescale 1ns/100ps
module test_sdram_command_address_decode;
  import sdram_cmd_pkg::*;
  logic mclk = 1'b0, sys_rst = 1'b1, clockEnable = 1'b1, dataMask = 1'b0;
  logic [1:0] orgSelect = 2'h0;
  wire chipSelect_n, rowStrobe_n, columnStrobe_n, writeStrobe_n;
  wire array_select_bit0, array_select_bit1;
  wire [11:0] addressPins;
  cmd_t command;
  clk_mode_t clockMode;
  logic commandValid, auto_precharge_flag, burstActive, writeBlocked, readOutputEnable;
  logic [11:0] row_address, column_address;
  logic [1:0] bankSelect;
  logic [3:0] bankOpen;
  int n_mismatch = 0, check_count = 0, cyc = 0;
  sdram_cmd_decode sdram_cmd_decode_i (.*);
  sdram_ctrl_model sdram_ctrl_model_i (.*);
  initial forever #25 mclk = ~mclk;
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic go(input logic [2:0] c, input logic [11:0] a, input logic [1:0] b, input logic s);
    sdram_ctrl_model_i.issue(c, a, b, s);
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic t_act;
    chk(clockMode === CLK_RUN && bankOpen === 4'h0, "reset state");
    go(3'h3, 12'hABC, 2'h2, 1'b0);
    chk(commandValid && command === CMD_ACT && row_address === 12'hABC, "act");
    go(3'h3, 12'h123, 2'h0, 1'b0);
    chk(bankOpen === 4'h5, "bank");
    go(3'h2, 12'h400, 2'h0, 1'b1);
    chk(!commandValid && bankOpen === 4'h5, "deselect");
  endtask
  task automatic t_burst(input logic [1:0] org, input logic [2:0] c, input logic [11:0] a,
      input logic [11:0] col, input logic [3:0] open);
    @(negedge mclk) orgSelect = org;
    go(c, a, a[11:10] == 2'h3 ? 2'h2 : 2'h0, 1'b0);
    chk((column_address & col) === (a & col) && burstActive, "column");
    repeat (4) @(posedge mclk);
    #1;
    chk(!burstActive && bankOpen === open, "burst end");
  endtask
  task automatic t_pre;
    go(3'h3, 12'h055, 2'h3, 1'b0);
    go(3'h2, 12'h000, 2'h3, 1'b0);
    chk(bankOpen === 4'h1, "precharge one");
    go(3'h2, 12'h400, 2'h2, 1'b0);
    chk(bankOpen === 4'h0, "precharge all");
  endtask
  task automatic t_power;
    @(negedge mclk) clockEnable = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    chk(clockMode === CLK_POWERDOWN, "power-down");
    go(3'h3, 12'h0AA, 2'h1, 1'b0);
    chk(!commandValid && bankOpen === 4'h1, "gated");
    @(negedge mclk) clockEnable = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk(clockMode === CLK_RUN, "wake");
  endtask
  task automatic t_suspend;
    go(3'h5, 12'h010, 2'h0, 1'b0);
    @(negedge mclk) clockEnable = 1'b0;
    repeat (6) @(posedge mclk);
    #1;
    chk(clockMode === CLK_SUSPEND && burstActive, "suspend");
    @(negedge mclk) clockEnable = 1'b1;
    repeat (5) @(posedge mclk);
    #1;
    chk(clockMode === CLK_RUN && !burstActive && bankOpen === 4'h1, "resume");
  endtask
  task automatic t_selfref;
    fork
      sdram_ctrl_model_i.issue(3'h1, 12'h000, 2'h0, 1'b0);
      @(negedge mclk) clockEnable = 1'b0;
    join
    repeat (2) @(posedge mclk);
    #1;
    chk(commandValid && command === CMD_REF && clockMode === CLK_SELFREF, "selfref");
    @(negedge mclk) clockEnable = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk(clockMode === CLK_RUN, "selfref exit");
  endtask
  task automatic t_mask;
    @(negedge mclk) dataMask = 1'b1;
    @(negedge mclk) dataMask = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk(writeBlocked && readOutputEnable, "write mask");
    repeat (2) @(posedge mclk);
    #1;
    chk(!writeBlocked && !readOutputEnable, "read mask");
    @(posedge mclk);
    #1;
    chk(readOutputEnable, "read unmask");
  endtask
  task automatic wrap_up;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    @(negedge mclk) sys_rst = 1'b0;
    t_act;
    t_burst(2'h0, 3'h5, 12'hC05, 12'hBFF, 4'h1);
    t_burst(2'h1, 3'h5, 12'h3FF, 12'h3FF, 4'h1);
    t_burst(2'h2, 3'h4, 12'h9FF, 12'h1FF, 4'h1);
    t_power;
    t_suspend;
    t_selfref;
    t_mask;
    t_pre;
    wrap_up;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 1000) begin
      n_mismatch++;
      wrap_up;
    end
  end
endmodule // test_sdram_command_address_decode
